// [bench/pin_world.sv]
/*
  Far-side model of the port pads: resolves each pin level from the
  device drivers, weak pulls and an external driver set by the bench.
  Assumes all inputs come from flops clocked by hclk.
*/
`timescale 1ns/1ps
module pin_world (
  input  wire logic        hclk,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pull_up,
  input  wire logic [15:0] pull_dn,
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_val,
  output logic      [15:0] pin_in
);
  logic [15:0] float_pat = 16'h5555;

  // an undriven, unpulled pin wanders rather than holding its last level
  always_ff @(posedge hclk) begin
    float_pat <= ~float_pat;
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i]; // bench never drives a pin the device drives
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pull_up[i]) begin
        pin_in[i] = 1'b1;
      end else if (pull_dn[i]) begin
        pin_in[i] = 1'b0;
      end else begin
        pin_in[i] = float_pat[i];
      end
    end
  end
endmodule

// [bench/test_gpio_port_bit_control.sv]
/*
  Self-checking bench for the port: AHB-Lite register tasks, pin checks
  against the pad model, lock and remap sequences.
  Assumes zero-wait slave behaviour may vary; every wait is bounded.
*/
`timescale 1ns/1ps
module test_gpio_port_bit_control;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] pin_in, pin_out, pin_oe, pull_up, pull_dn, in_en, pis;
  logic [31:0] slew_code;
  logic [15:0] af_out = 16'h0;
  logic [15:0] ext_en = 16'h0;
  logic [15:0] ext_val = 16'h0;
  logic [31:0] rd;
  int          bad_count = 0;
  int          total_checks = 0;

  assign hready = hreadyout;

  initial begin
    forever #12.5 hclk = ~hclk;
  end

  gpio_port #(.PULLUP_RST_MASK(16'hA000), .PULLDN_RST_MASK(16'h4000)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up(pull_up), .pull_dn(pull_dn), .in_en(in_en), .slew_code(slew_code), .af_out(af_out),
    .peripheral_input_signal(pis));

  pin_world i_pins (
    .hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pull_up), .pull_dn(pull_dn),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  // one single transfer; call right after a rising edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 3'h2);
  endtask

  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0, 3'h2);
    chk(what, exp, rd);
  endtask

  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("cfg_lo", 32'h00, 32'h44444444);
    rchk("cfg_hi", 32'h04, 32'h88844444);
    rchk("odr", 32'h0C, 32'h0000A000);
    chk("pu", 32'hA000, {16'h0, pull_up});
    chk("pd", 32'h4000, {16'h0, pull_dn});
    chk("oe", 32'h0, {16'h0, pin_oe});
    chk("ie", 32'hFFFF, {16'h0, in_en});
    $display("test reset done");

    // pin0 pp 50M, pin1 od 10M, pin2 periph pp 2M, pin3 analog, pin4 pulled
    af_out <= 16'h0400;
    wr(32'h00, 32'h44480A53);
    wr(32'h0C, 32'h00000013);
    settle();
    chk("oe4", 32'h05, {27'h0, pin_oe[4:0]});
    chk("out", 32'h1, {29'h0, pin_out[2:0] & 3'h5});
    chk("pu4", 32'h10, {27'h0, pull_up[4:0]});
    chk("ie4", 32'h17, {27'h0, in_en[4:0]});
    chk("slew", 32'h27, {22'h0, slew_code[9:0]});
    wr(32'h0C, 32'h0);
    settle();
    chk("oe4z", 32'h07, {27'h0, pin_oe[4:0]});
    chk("pd4", 32'h10, {27'h0, pull_dn[4:0]});
    $display("test modes done");

    ext_en <= 16'hFFE0;
    ext_val <= 16'h5A40;
    settle();
    rchk("idr", 32'h08, 32'h5A40);
    chk("pis", 32'h5A40, {16'h0, pis});
    wr(32'h1C, 32'h04);
    settle();
    chk("remap_out", 32'h1, {31'h0, pin_out[2]});
    chk("remap_in", 32'h5E40, {16'h0, pis});
    rchk("remap", 32'h1C, 32'h04);
    // clock enable low must hold every flop, sampled pins included
    ce <= 1'b0;
    ext_val <= 16'h0000;
    settle();
    chk("freeze", 32'h5E40, {16'h0, pis});
    ce <= 1'b1;
    settle();
    chk("thaw", 32'h0400, {16'h0, pis});
    ext_val <= 16'h5A40;
    settle();
    $display("test input and remap done");

    wr(32'h10, 32'h00030005);
    rchk("odr_bsc", 32'h0C, 32'h0005);
    wr(32'h14, 32'h0004);
    rchk("odr_bclr", 32'h0C, 32'h0001);
    rchk("bsc_rd", 32'h10, 32'h0);
    wr(32'h08, 32'hFFFF);
    settle();
    rchk("idr_ro", 32'h08, 32'h5A45);
    bus(32'h0C, 1'b1, 32'hFFFF, 3'h0);
    rchk("odr_byte", 32'h0C, 32'h0001);
    rchk("unalign", 32'h0D, 32'h0);
    rchk("unmapped", 32'h2C, 32'h0);
    $display("test set clear done");

    wr(32'h18, 32'h00010002);
    rchk("lck_abort", 32'h18, 32'h00000002);
    wr(32'h18, 32'h00010001);
    wr(32'h18, 32'h00000001);
    wr(32'h18, 32'h00010001);
    bus(32'h18, 1'b0, 32'h0, 3'h2);
    bus(32'h18, 1'b0, 32'h0, 3'h2);
    chk("lck_key", 32'h1, {31'h0, rd[16]});
    wr(32'h00, 32'h44444444);
    rchk("cfg_locked", 32'h00, 32'h44444443);
    $display("test lock done");
    report_and_stop();
  end
endmodule

// [hdl/gpio_pkg.sv]
/*
  Shared constants for the 16-bit general-purpose I/O port: register
  word indices, configuration codes, reset values and lock states.
  Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
*/
package gpio_pkg;
  localparam int unsigned NPINS = 16;

  // register word index, byte address is index * 4
  localparam logic [2:0] IDX_CFG_LO = 3'h0;
  localparam logic [2:0] IDX_CFG_HI = 3'h1;
  localparam logic [2:0] IDX_IDR    = 3'h2;
  localparam logic [2:0] IDX_ODR    = 3'h3;
  localparam logic [2:0] IDX_BSC    = 3'h4;
  localparam logic [2:0] IDX_BCLR   = 3'h5;
  localparam logic [2:0] IDX_LOCK   = 3'h6;
  localparam logic [2:0] IDX_REMAP  = 3'h7;

  // direction/speed code
  localparam logic [1:0] MODE_IN     = 2'h0;
  // pin_config_code values in input direction
  localparam logic [1:0] KIND_ANALOG  = 2'h0;
  localparam logic [1:0] KIND_FLOAT   = 2'h1;
  localparam logic [1:0] KIND_PULL    = 2'h2;
  // pin_config_code bit meaning in output direction
  localparam int unsigned KIND_OD_BIT = 0;
  localparam int unsigned KIND_AF_BIT = 1;

  // nibble layout {pin_config_code, mode}
  localparam logic [3:0] CFG_RST      = 4'h4;
  localparam logic [3:0] CFG_PULL_RST = 4'h8;

  localparam int unsigned LCK_KEY_POS = 16;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;
  localparam logic [4:0]  HIGH_ADDR_ZERO = 5'h00;

  typedef enum logic [2:0] {
    L_IDLE   = 3'b000,
    L_GOT1   = 3'b001,
    L_GOT0   = 3'b010,
    L_GOT1B  = 3'b011,
    L_READ1  = 3'b100,
    L_LOCKED = 3'b101
  } lck_e;
endpackage

// [hdl/gpio_port.sv]
/*
  16-bit general-purpose I/O port with AHB-Lite register slave, atomic
  set/clear, configuration lock and peripheral pin remapping.
  Assumes pins and peripheral signals are synchronous to hclk; pads and
  the tri-state buffer sit outside and use pin_out/pin_oe.
*/
// Notes on behaviour
// - two-bit mode code selects input or output mode
// - output mode codes give slew class
// - reset leaves every bit floating input except those in PULLUP_RST_MASK or PULLDN_RST_MASK
// - debug pins reset as pulled inputs
// - general output drives stored output data
// - open-drain drives low only; push-pull both
// - input data sampled every clock while ce is high
// - reads give sampled pins, written output data
// - input: driver off, sampler on except in analog, pulls chosen
// - output: pulls off, sampler on
// - set/clear writes touch only ones
// - peripheral output replaces output data
// - idle peripheral gives undefined pin level
// - peripheral inputs use input modes, floating
// - remap moves peripheral signals off default pin
// - locked bits keep configuration until reset
`timescale 1ns/1ps
module gpio_port #(
  parameter logic [15:0] PULLUP_RST_MASK = 16'h0000,
  parameter logic [15:0] PULLDN_RST_MASK = 16'h0000
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] pin_in,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe,
  output logic      [15:0] pull_up,
  output logic      [15:0] pull_dn,
  output logic      [15:0] in_en,
  output logic      [31:0] slew_code,
  input  wire logic [15:0] af_out,
  output logic      [15:0] peripheral_input_signal
);
  localparam int unsigned N = gpio_pkg::NPINS;

  if ((PULLUP_RST_MASK & PULLDN_RST_MASK) != 16'h0000) begin : g_bad_mask
    $error("a pin cannot reset both pulled up and pulled down");
  end

  typedef struct packed {
    logic [63:0]      cfg;
    logic [15:0]      odr;
    logic [15:0]      idr;
    logic [15:0]      lck_sel;
    logic [15:0]      lck_mask;
    logic             lck_key;
    gpio_pkg::lck_e   lst;
    logic [7:0]       remap;
    logic             ap_wr;
    logic [2:0]       ap_idx;
    logic [31:0]      rdata;
    logic             rdy;
    logic [15:0]      pout;
    logic [15:0]      poe;
    logic [15:0]      pu;
    logic [15:0]      pd;
    logic [15:0]      ie;
    logic [15:0]      pin_per;
    logic [31:0]      slew;
  } st_s;

  function automatic logic [63:0] cfg_init();
    logic [63:0] v;
    v = '0;
    for (int i = 0; i < N; i++) begin
      v[4*i +: 4] = (PULLUP_RST_MASK[i] | PULLDN_RST_MASK[i]) ? gpio_pkg::CFG_PULL_RST
                                                             : gpio_pkg::CFG_RST;
    end
    return v;
  endfunction

  // bit k of remap swaps pins k and k+8 for peripheral signals
  function automatic logic [15:0] route(input logic [15:0] v, input logic [7:0] rm);
    logic [15:0] o;
    o = v;
    for (int k = 0; k < 8; k++) begin
      if (rm[k]) begin
        o[k]   = v[k+8];
        o[k+8] = v[k];
      end
    end
    return o;
  endfunction

  function automatic logic [31:0] rd_word(input st_s s, input logic [2:0] idx);
    logic [31:0] w;
    w = '0;
    unique case (idx)
      gpio_pkg::IDX_CFG_LO: w = s.cfg[31:0];
      gpio_pkg::IDX_CFG_HI: w = s.cfg[63:32];
      gpio_pkg::IDX_IDR:    w = {16'h0000, s.idr};
      gpio_pkg::IDX_ODR:    w = {16'h0000, s.odr};
      gpio_pkg::IDX_LOCK:   w = {15'h0000, s.lck_key, s.lck_sel};
      gpio_pkg::IDX_REMAP:  w = {24'h000000, s.remap};
      default:              w = '0;
    endcase
    return w;
  endfunction

  localparam st_s ST_RST = '{
    cfg: cfg_init(), odr: PULLUP_RST_MASK, idr: '0, lck_sel: '0, lck_mask: '0,
    lck_key: 1'b0, lst: gpio_pkg::L_IDLE, remap: '0, ap_wr: 1'b0, ap_idx: '0,
    rdata: '0, rdy: 1'b1, pout: '0, poe: '0, pu: PULLUP_RST_MASK, pd: PULLDN_RST_MASK,
    ie: 16'hFFFF, pin_per: '0, slew: '0};

  st_s r;
  st_s n;

  logic [15:0] c_drv;
  logic [15:0] c_oe;
  logic [15:0] c_pu;
  logic [15:0] c_pd;
  logic [15:0] c_ie;
  logic [15:0] af_pin;

  ////////////////////////////////////////////////////////////////////////
  // per-bit pad control

  assign af_pin = route(af_out, r.remap);

  for (genvar g = 0; g < N; g++) begin : g_pin
    pin_cell u_cell (
      .cfg    (r.cfg[4*g +: 4]),
      .odr    (r.odr[g]),
      .af_val (af_pin[g]),
      .drv    (c_drv[g]),
      .oe     (c_oe[g]),
      .pu     (c_pu[g]),
      .pd     (c_pd[g]),
      .ie     (c_ie[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave and register behaviour

  logic        take;
  logic        hit;
  logic        lck_rd;
  logic        key;
  logic [15:0] sel;

  always_comb begin
    n      = r;
    key    = hwdata[gpio_pkg::LCK_KEY_POS];
    sel    = hwdata[15:0];
    take   = hsel & htrans[1] & hready;
    // narrow accesses are ignored but still answered OKAY
    hit    = (haddr[9:5] == gpio_pkg::HIGH_ADDR_ZERO) && (haddr[1:0] == 2'h0)
             && (hsize == gpio_pkg::HSIZE_WORD);
    lck_rd = take & ~hwrite & hit & (haddr[4:2] == gpio_pkg::IDX_LOCK);

    if (r.ap_wr) begin
      unique case (r.ap_idx)
        gpio_pkg::IDX_CFG_LO, gpio_pkg::IDX_CFG_HI: begin
          for (int i = 0; i < N; i++) begin
            if (((i >= 8) == (r.ap_idx == gpio_pkg::IDX_CFG_HI)) && !r.lck_mask[i]) begin
              n.cfg[4*i +: 4] = hwdata[4*(i%8) +: 4];
            end
          end
        end
        gpio_pkg::IDX_ODR:   n.odr = hwdata[15:0];
        gpio_pkg::IDX_BSC:   n.odr = (r.odr & ~hwdata[31:16]) | hwdata[15:0];
        gpio_pkg::IDX_BCLR:  n.odr = r.odr & ~hwdata[15:0];
        gpio_pkg::IDX_REMAP: n.remap = hwdata[7:0];
        gpio_pkg::IDX_LOCK: begin
          if (!r.lck_key) begin
            // any off-sequence write restarts or aborts
            n.lst     = key ? gpio_pkg::L_GOT1 : gpio_pkg::L_IDLE;
            n.lck_sel = sel;
            if (r.lst == gpio_pkg::L_GOT1 && !key && sel == r.lck_sel) begin
              n.lst = gpio_pkg::L_GOT0;
            end else if (r.lst == gpio_pkg::L_GOT0 && key && sel == r.lck_sel) begin
              n.lst = gpio_pkg::L_GOT1B;
            end
          end
        end
        default: ;
      endcase
    end

    if (lck_rd && !n.lck_key) begin
      unique case (n.lst)
        gpio_pkg::L_GOT1B: n.lst = gpio_pkg::L_READ1;
        gpio_pkg::L_READ1: begin
          n.lst      = gpio_pkg::L_LOCKED;
          n.lck_key  = 1'b1;
          n.lck_mask = n.lck_sel;
        end
        default: n.lst = gpio_pkg::L_IDLE;
      endcase
    end

    // sampled through the registered sampler enable; analog reads zero
    n.idr     = pin_in & r.ie;
    n.pin_per = route(n.idr, r.remap);

    n.ap_wr  = take & hwrite & hit;
    n.ap_idx = haddr[4:2];
    if (take && !hwrite) begin
      // read from the next state so a write just ahead is seen
      n.rdata = hit ? rd_word(n, haddr[4:2]) : 32'h00000000;
    end
    n.rdy = 1'b1;

    n.pout = c_drv;
    n.poe  = c_oe;
    n.pu   = c_pu;
    n.pd   = c_pd;
    n.ie   = c_ie;
    for (int i = 0; i < N; i++) begin
      n.slew[2*i +: 2] = r.cfg[4*i +: 2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= ST_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  assign hrdata                  = r.rdata;
  assign hreadyout               = r.rdy;
  assign hresp                   = 1'b0;
  assign pin_out                 = r.pout;
  assign pin_oe                  = r.poe;
  assign pull_up                 = r.pu;
  assign pull_dn                 = r.pd;
  assign in_en                   = r.ie;
  assign slew_code               = r.slew;
  assign peripheral_input_signal = r.pin_per;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic [15:0] in_m;
  logic [15:0] od_m;
  logic [15:0] gp_pp_m;
  logic [15:0] af_pp_m;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      in_m[i]    = r.cfg[4*i +: 2] == gpio_pkg::MODE_IN;
      od_m[i]    = !in_m[i] && r.cfg[4*i+2+gpio_pkg::KIND_OD_BIT];
      gp_pp_m[i] = !in_m[i] && r.cfg[4*i+2 +: 2] == 2'h0;
      af_pp_m[i] = !in_m[i] && r.cfg[4*i+2 +: 2] == 2'h2;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_lock_armed;
    r.lst == gpio_pkg::L_READ1 && !r.lck_key;
  endsequence
  sequence s_final_read;
    s_lock_armed ##0 (lck_rd && ce && !r.ap_wr);
  endsequence

  reset_config_a: assert property ($rose(hresetn) |-> r.cfg == cfg_init() && r.lck_key == 1'b0)
    else $error("configuration not at reset value");
  od_no_high_a: assert property (ce |=> ((pin_oe & pin_out & $past(od_m)) == 16'h0000))
    else $error("open-drain pin driven high");
  in_no_drive_a: assert property (ce |=> ((pin_oe & $past(in_m)) == 16'h0000))
    else $error("input pin has driver on");
  out_no_pull_a: assert property (ce |=> (((pull_up | pull_dn) & ~$past(in_m)) == 16'h0000))
    else $error("output pin has a pull on");
  // the release edge still runs the reset branch, so it is no sample point
  idr_sample_a: assert property (ce && hresetn |=> r.idr == ($past(pin_in) & $past(in_en)))
    else $error("input data not sampled");
  gp_drive_a: assert property (ce |=> (((pin_out ^ $past(r.odr)) & $past(gp_pp_m)) == 16'h0000))
    else $error("general output not from output data");
  af_drive_a: assert property (ce |=> (((pin_out ^ $past(af_pin)) & $past(af_pp_m)) == 16'h0000))
    else $error("peripheral output not routed");
  bsc_write_a: assert property ((ce && r.ap_wr && r.ap_idx == gpio_pkg::IDX_BSC) |=>
      r.odr == (($past(r.odr) & ~$past(hwdata[31:16])) | $past(hwdata[15:0])))
    else $error("set/clear write wrong");
  lock_take_a: assert property (s_final_read |=> r.lck_key && r.lck_mask == $past(r.lck_sel))
    else $error("lock did not engage");
  lock_hold_a: assert property (ce && r.lck_key |=>
      (($past(r.cfg) ^ r.cfg) & {{4{r.lck_mask[15]}}, {4{r.lck_mask[14]}}, {4{r.lck_mask[13]}},
      {4{r.lck_mask[12]}}, {4{r.lck_mask[11]}}, {4{r.lck_mask[10]}}, {4{r.lck_mask[9]}},
      {4{r.lck_mask[8]}}, {4{r.lck_mask[7]}}, {4{r.lck_mask[6]}}, {4{r.lck_mask[5]}},
      {4{r.lck_mask[4]}}, {4{r.lck_mask[3]}}, {4{r.lck_mask[2]}}, {4{r.lck_mask[1]}},
      {4{r.lck_mask[0]}}}) == 64'h0)
    else $error("locked configuration changed");
endmodule

// [hdl/pin_cell.sv]
/*
  Combinational control of one port bit: output driver, weak pulls and
  input sampler enable, from the bit's configuration nibble.
  Assumes the caller registers every result before it reaches a pad.
*/
`timescale 1ns/1ps
module pin_cell (
  input  wire logic [3:0] cfg,
  input  wire logic       odr,
  input  wire logic       af_val,
  output logic            drv,
  output logic            oe,
  output logic            pu,
  output logic            pd,
  output logic            ie
);
  logic [1:0] mode;
  logic [1:0] kind;
  logic       src;

  always_comb begin
    mode = cfg[1:0];
    kind = cfg[3:2];
    src  = 1'b0;
    drv  = 1'b0;
    oe   = 1'b0;
    pu   = 1'b0;
    pd   = 1'b0;
    ie   = 1'b1;
    if (mode == gpio_pkg::MODE_IN) begin
      // analog parks the sampler so the data register reads zero
      ie = (kind != gpio_pkg::KIND_ANALOG);
      pu = (kind == gpio_pkg::KIND_PULL) & odr;
      pd = (kind == gpio_pkg::KIND_PULL) & ~odr;
    end else begin
      // peripheral value, undefined when the peripheral is idle
      src = kind[gpio_pkg::KIND_AF_BIT] ? af_val : odr;
      if (kind[gpio_pkg::KIND_OD_BIT]) begin
        drv = 1'b0;
        oe  = ~src;
      end else begin
        drv = src;
        oe  = 1'b1;
      end
    end
  end
endmodule
